// File: sepg_top.sv
`timescale 1ns/10ps
// status event logic and total pressure gate
module sepg_top
	import sepg_pkg::*;
(
	input  wire logic                 MCLK,
	input  wire logic                 RST_N,
	input  wire logic [NGRP*NBIT-1:0] COND,
	input  wire logic                 CMD_VALID,
	input  wire logic [3:0]           CMD_CODE,
	input  wire logic [3:0]           CMD_GRP,
	input  wire logic                 CMD_SINGLE,
	input  wire logic [3:0]           CMD_BIT,
	input  wire logic [15:0]          CMD_DATA,
	output logic                      RSP_VALID,
	output logic [15:0]               RSP_DATA,
	input  wire logic                 MULT_VOLT_NZ,
	input  wire logic                 SCAN_END,
	input  wire logic                 TP_QUERY,
	output logic                      MEAS_START,
	input  wire logic                 MEAS_DONE,
	input  wire logic [31:0]          MEAS_FLOAT,
	output logic                      TP_BIN_VALID,
	output logic [7:0]                TP_BIN_BYTE,
	output logic                      TP_ASC_VALID,
	output logic [7:0]                TP_ASC_BYTE,
	output logic                      TP_RAW_VALID,
	output logic [31:0]               TP_RAW,
	output logic                      TP_ENABLED,
	output logic                      SERVICE_LED,
	output logic [9:0]                GLOBAL_SUM
);
	localparam int NB = NGRP*NBIT;

	function automatic logic [15:0] grp_slice(input logic [NB-1:0] v, input logic [3:0] g);
		grp_slice = v[g*NBIT +: NBIT];
	endfunction

	// command decode
	wire is_cond_rd = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_COND_RD;
	wire is_evt_rd  = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_EVT_RD;
	wire is_en_rd   = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_EN_RD;
	wire is_en_wr   = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_EN_WR;
	wire is_assert  = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_ASSERT;
	wire is_defmask = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_DEFMASK;
	wire is_glob_rd = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_GLOBAL_RD;
	wire is_svc_rd  = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_SVC_RD;
	wire is_svc_wr  = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_SVC_WR;
	wire is_tpe_wr  = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_TP_EN_WR;
	wire is_tpe_rd  = CMD_VALID && sepg_cmd_t'(CMD_CODE) == CMD_TP_EN_RD;
	wire grp_ok     = CMD_GRP <= LAST_GRP;

	logic [NB-1:0]  cond_prev_ff;
	logic [NB-1:0]  evt_ff;
	logic [NB-1:0]  en_all;
	logic [9:0]     svc_mask_ff;
	logic           tp_en_ff;
	logic           mult_prev_ff;

	// enable write mask: whole group or one bit
	wire [15:0] bit_sel  = 16'h0001 << CMD_BIT;
	wire [15:0] en_wmask = CMD_SINGLE ? bit_sel : 16'hffff;
	wire [15:0] en_wdata = CMD_SINGLE ? (CMD_DATA[0] ? bit_sel : 16'h0000) : CMD_DATA;

	sepg_grp_mem i_sepg_grp_mem (
		.clk      (MCLK),
		.rst_n    (RST_N),
		.defaults (is_defmask),
		.wr       (is_en_wr && grp_ok),
		.wr_grp   (CMD_GRP),
		.wr_data  (en_wdata),
		.wr_mask  (en_wmask),
		.en_all   (en_all)
	);

	// event set and clear
	wire [NB-1:0] rise      = COND & ~cond_prev_ff & en_all;
	wire [NB-1:0] set_vec   = rise | (is_assert ? COND : '0);
	wire [NB-1:0] grp_mask  = NB'({16'h0000, en_wmask}) << (CMD_GRP*NBIT);
	wire [NB-1:0] clr_vec   = (is_evt_rd && grp_ok) ? grp_mask : '0;
	wire [NB-1:0] nxt_evt   = (evt_ff & ~clr_vec) | set_vec;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			evt_ff       <= '0;
			cond_prev_ff <= '1;
		end else begin
			evt_ff       <= nxt_evt;
			cond_prev_ff <= COND;
		end
	end

	// per-group summary
	logic [9:0] grp_act;
	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : gs
			assign grp_act[g] = |(evt_ff[g*NBIT +: NBIT] & en_all[g*NBIT +: NBIT]);
		end
	endgenerate
	assign GLOBAL_SUM  = grp_act;
	assign SERVICE_LED = |(grp_act & svc_mask_ff);

	// service mask
	wire [9:0] svc_bit = 10'h001 << CMD_GRP;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			svc_mask_ff <= SVC_RST;
		else if (is_defmask)
			svc_mask_ff <= SVC_RST;
		else if (is_svc_wr && CMD_SINGLE && grp_ok)
			svc_mask_ff <= CMD_DATA[0] ? (svc_mask_ff | svc_bit) : (svc_mask_ff & ~svc_bit);
		else if (is_svc_wr && !CMD_SINGLE)
			svc_mask_ff <= CMD_DATA[9:0];
	end

	// total pressure enable
	wire mult_rise = MULT_VOLT_NZ && !mult_prev_ff;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tp_en_ff     <= TP_EN_RST;
			mult_prev_ff <= 1'b0;
		end else begin
			mult_prev_ff <= MULT_VOLT_NZ;
			if (mult_rise)
				tp_en_ff <= 1'b0;
			else if (is_tpe_wr)
				tp_en_ff <= CMD_DATA[0];
		end
	end
	assign TP_ENABLED = tp_en_ff;

	// register reads
	wire [15:0] c_grp = grp_slice(COND, CMD_GRP);
	wire [15:0] e_grp = grp_slice(evt_ff, CMD_GRP);
	wire [15:0] n_grp = grp_slice(en_all, CMD_GRP);
	function automatic logic [15:0] pick(input logic [15:0] v, input logic s, input logic [3:0] b);
		pick = s ? {15'h0000, v[b]} : v;
	endfunction
	logic [15:0] nxt_rsp;
	always_comb begin
		nxt_rsp = 16'h0000;
		if (is_cond_rd && grp_ok)
			nxt_rsp = pick(c_grp, CMD_SINGLE, CMD_BIT);
		else if (is_evt_rd && grp_ok)
			nxt_rsp = pick(e_grp, CMD_SINGLE, CMD_BIT);
		else if (is_en_rd && grp_ok)
			nxt_rsp = pick(n_grp, CMD_SINGLE, CMD_BIT);
		else if (is_glob_rd)
			nxt_rsp = CMD_SINGLE ? {15'h0000, grp_ok && grp_act[CMD_GRP]} : {6'h00, grp_act};
		else if (is_svc_rd)
			nxt_rsp = CMD_SINGLE ? {15'h0000, grp_ok && svc_mask_ff[CMD_GRP]}
			                     : {6'h00, svc_mask_ff};
		else if (is_tpe_rd)
			nxt_rsp = {15'h0000, tp_en_ff};
	end
	wire rd_any = is_cond_rd | is_evt_rd | is_en_rd | is_glob_rd | is_svc_rd | is_tpe_rd;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			RSP_VALID <= 1'b0;
			RSP_DATA  <= 16'h0000;
		end else begin
			RSP_VALID <= rd_any;
			RSP_DATA  <= nxt_rsp;
		end
	end

	// total pressure sequencer
	sepg_tp_t   tp_st_ff;
	logic       tp_ascii_ff;
	logic [31:0] tp_val_ff;
	logic [1:0] tp_idx_ff;
	wire tp_req = SCAN_END | TP_QUERY;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tp_st_ff    <= TP_IDLE;
			tp_ascii_ff <= 1'b0;
			tp_val_ff   <= FLOAT_ZERO;
			tp_idx_ff   <= 2'd0;
		end else begin
			unique case (tp_st_ff)
				TP_IDLE: begin
					tp_idx_ff <= 2'd0;
					if (tp_req) begin
						tp_ascii_ff <= TP_QUERY && !SCAN_END;
						tp_val_ff   <= FLOAT_ZERO;
						tp_st_ff    <= tp_en_ff ? TP_MEAS : TP_SEND;
					end
				end
				TP_MEAS: if (MEAS_DONE) begin
					tp_val_ff <= MEAS_FLOAT;
					tp_st_ff  <= TP_SEND;
				end
				TP_SEND: begin
					tp_idx_ff <= tp_idx_ff + 2'd1;
					if (tp_ascii_ff ? (tp_idx_ff == 2'(ASCII_ZLEN-1) || tp_val_ff != FLOAT_ZERO)
					                : tp_idx_ff == 2'd3)
						tp_st_ff <= TP_IDLE;
				end
			endcase
		end
	end
	assign MEAS_START   = tp_st_ff == TP_IDLE && tp_req && tp_en_ff;
	wire sending        = tp_st_ff == TP_SEND;
	assign TP_BIN_VALID = sending && !tp_ascii_ff;
	assign TP_BIN_BYTE  = tp_val_ff[tp_idx_ff*8 +: 8];
	// disabled or zero query spells "0.0"; a live value goes out raw for the formatter
	wire zero_val       = tp_val_ff == FLOAT_ZERO;
	assign TP_ASC_VALID = sending && tp_ascii_ff && zero_val;
	assign TP_ASC_BYTE  = tp_idx_ff == 2'd1 ? ASCII_DOT : ASCII_0;
	assign TP_RAW_VALID = sending && tp_ascii_ff && !zero_val;
	assign TP_RAW       = tp_val_ff;

	// cycles spent in one send, for the length check below
	logic [2:0] send_len_ff;
	wire  [2:0] nxt_send_len = sending ? send_len_ff + 3'd1 : 3'd0;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			send_len_ff <= 3'd0;
		else
			send_len_ff <= nxt_send_len;
	end

	// event bits
	AST_EVT_NEED_COND: assert property (@(posedge MCLK) disable iff (!RST_N)
		1'b1 |=> (evt_ff & ~$past(evt_ff) & ~$past(COND)) == '0)
		else $error("event set without condition");
	AST_EVT_NEED_EN: assert property (@(posedge MCLK) disable iff (!RST_N)
		!is_assert |=> (evt_ff & ~$past(evt_ff) & ~$past(en_all)) == '0)
		else $error("event set while disabled");
	AST_EVT_NEED_EDGE: assert property (@(posedge MCLK) disable iff (!RST_N)
		!is_assert |=> (evt_ff & ~$past(evt_ff) & $past(COND, 2)) == '0)
		else $error("event set without rising condition");
	AST_EVT_KEEP: assert property (@(posedge MCLK) disable iff (!RST_N)
		!(is_evt_rd && grp_ok) |=> ($past(evt_ff) & ~evt_ff) == '0)
		else $error("event lost without read");
	AST_EVT_BIT_ONLY: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_evt_rd && CMD_SINGLE) |=> ($past(evt_ff) & ~evt_ff & ~$past(grp_mask)) == '0)
		else $error("bit read cleared other bits");
	AST_EVT_SEL_CLR: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_evt_rd && grp_ok && (set_vec & grp_mask) == '0) |=> (evt_ff & $past(grp_mask)) == '0)
		else $error("read events not cleared");
	AST_SET_WINS: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_evt_rd && (rise & grp_mask) != '0) |=> (evt_ff & $past(rise & grp_mask)) != '0)
		else $error("clear beat a new event");

	// register reads
	AST_COND_RD: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_cond_rd && !CMD_SINGLE && grp_ok) |=> RSP_DATA == grp_slice($past(COND), $past(CMD_GRP)))
		else $error("condition group read wrong");
	AST_COND_RD_KEEP: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_cond_rd && set_vec == '0) |=> $stable(evt_ff) && $stable(en_all))
		else $error("condition read altered state");
	AST_EVT_RD: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_evt_rd && !CMD_SINGLE && grp_ok) |=> RSP_DATA == grp_slice($past(evt_ff), $past(CMD_GRP)))
		else $error("event group read wrong");
	AST_EVT_RD_BIT: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_evt_rd && CMD_SINGLE) |=> RSP_VALID && RSP_DATA[15:1] == 15'h0000)
		else $error("event bit read not 0/1");
	AST_BAD_GRP: assert property (@(posedge MCLK) disable iff (!RST_N)
		((is_cond_rd || is_evt_rd || is_en_rd) && !grp_ok) |=> RSP_DATA == 16'h0000)
		else $error("bad group read not zero");
	AST_TPE_RD: assert property (@(posedge MCLK) disable iff (!RST_N)
		is_tpe_rd |=> RSP_DATA == {15'h0000, $past(tp_en_ff)})
		else $error("enable query wrong");

	// enables and masks
	AST_EN_DEFAULT: assert property (@(posedge MCLK) disable iff (!RST_N)
		is_defmask |=> en_all == {NGRP{EN_RST}})
		else $error("enables not restored");
	AST_SVC_DEFAULT: assert property (@(posedge MCLK) disable iff (!RST_N)
		is_defmask |=> svc_mask_ff == SVC_RST)
		else $error("service mask not restored");
	AST_EN_GRP_WR: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_en_wr && !CMD_SINGLE && grp_ok) |=> grp_slice(en_all, $past(CMD_GRP)) == $past(CMD_DATA))
		else $error("group enable write wrong");
	AST_EN_BIT_WR: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_en_wr && CMD_SINGLE && grp_ok) |=> (en_all & $past(grp_mask)) == ($past(CMD_DATA[0]) ? $past(grp_mask) : '0))
		else $error("bit enable write wrong");
	AST_EN_BIT_ONLY: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_en_wr && CMD_SINGLE) |=> ((en_all ^ $past(en_all)) & ~$past(grp_mask)) == '0)
		else $error("bit enable write touched others");
	AST_EN_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
		!(is_en_wr || is_defmask) |=> $stable(en_all))
		else $error("enables changed without write");

	// summary and service indicator
	AST_GSUM_IDLE: assert property (@(posedge MCLK) disable iff (!RST_N)
		(evt_ff & en_all) == '0 |-> GLOBAL_SUM == 10'h000)
		else $error("summary set with no event");
	AST_GSUM_TOP: assert property (@(posedge MCLK) disable iff (!RST_N)
		GLOBAL_SUM[9] == |(evt_ff[NB-1 -: NBIT] & en_all[NB-1 -: NBIT]))
		else $error("top group weight wrong");
	AST_LED_OFF: assert property (@(posedge MCLK) disable iff (!RST_N)
		svc_mask_ff == 10'h000 |-> !SERVICE_LED)
		else $error("led lit with empty mask");

	// total pressure gate
	AST_TPE_WR: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_tpe_wr && !mult_rise) |=> tp_en_ff == $past(CMD_DATA[0]))
		else $error("enable write lost");
	AST_TPE_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
		!(is_tpe_wr || mult_rise) |=> $stable(tp_en_ff))
		else $error("enable changed by itself");
	AST_ZERO_OFF: assert property (@(posedge MCLK) disable iff (!RST_N)
		(tp_st_ff == TP_IDLE && tp_req && !tp_en_ff) |=> sending && tp_val_ff == FLOAT_ZERO)
		else $error("disabled request not zero");
	AST_MEAS_TAKE: assert property (@(posedge MCLK) disable iff (!RST_N)
		(tp_st_ff == TP_MEAS && MEAS_DONE) |=> sending && tp_val_ff == $past(MEAS_FLOAT))
		else $error("measured value not taken");
	AST_TP_REQ: assert property (@(posedge MCLK) disable iff (!RST_N)
		(tp_st_ff == TP_IDLE && tp_req) |=> tp_st_ff != TP_IDLE)
		else $error("request ignored in idle");
	AST_SCAN_BIN: assert property (@(posedge MCLK) disable iff (!RST_N)
		(tp_st_ff == TP_IDLE && SCAN_END) |=> !tp_ascii_ff)
		else $error("scan end result not binary");
	AST_BIN_ORDER: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(TP_BIN_VALID) |-> TP_BIN_BYTE == tp_val_ff[7:0] ##1 TP_BIN_BYTE == tp_val_ff[15:8]
		##1 TP_BIN_BYTE == tp_val_ff[23:16] ##1 TP_BIN_BYTE == tp_val_ff[31:24])
		else $error("binary byte order wrong");
	AST_ASC_TEXT: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(TP_ASC_VALID) |-> TP_ASC_BYTE == ASCII_0 ##1 TP_ASC_BYTE == ASCII_DOT
		##1 TP_ASC_BYTE == ASCII_0 ##1 !TP_ASC_VALID)
		else $error("zero text wrong");
	AST_RAW_ONE: assert property (@(posedge MCLK) disable iff (!RST_N)
		TP_RAW_VALID |=> !TP_RAW_VALID)
		else $error("raw result longer than one cycle");
	AST_SEND_LEN: assert property (@(posedge MCLK) disable iff (!RST_N)
		sending |-> send_len_ff < 3'd4)
		else $error("send too long");

	AST_TP_OFF_ON_MULT: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(MULT_VOLT_NZ) |=> !tp_en_ff) else $error("enable not forced off");
	AST_NO_START_OFF: assert property (@(posedge MCLK) disable iff (!RST_N)
		!tp_en_ff |-> !MEAS_START) else $error("measurement started while disabled");
	AST_START_ON: assert property (@(posedge MCLK) disable iff (!RST_N)
		(tp_st_ff == TP_IDLE && SCAN_END && tp_en_ff) |-> MEAS_START) else $error("no start");
	AST_BIN_FOUR: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(TP_BIN_VALID) |-> TP_BIN_VALID[*4] ##1 !TP_BIN_VALID) else $error("not 4 bytes");
	AST_EVT_RISE: assert property (@(posedge MCLK) disable iff (!RST_N)
		(rise[0] && !is_evt_rd) |=> evt_ff[0]) else $error("event missed");
	AST_EVT_HELD: assert property (@(posedge MCLK) disable iff (!RST_N)
		(!evt_ff[0] && $past(COND[0]) && COND[0] && !is_assert) |=> !evt_ff[0])
		else $error("held condition set event");
	AST_EVT_CLR: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_evt_rd && !CMD_SINGLE && CMD_GRP == 4'h0 && !(|set_vec[15:0])) |=> evt_ff[15:0] == 16'h0)
		else $error("group not cleared");
	AST_ASSERT_CP: assert property (@(posedge MCLK) disable iff (!RST_N)
		is_assert |=> (evt_ff & $past(COND)) == $past(COND)) else $error("assert copy failed");
	AST_SVC: assert property (@(posedge MCLK) disable iff (!RST_N)
		SERVICE_LED == |(grp_act & svc_mask_ff)) else $error("service led mismatch");
	AST_RSP: assert property (@(posedge MCLK) disable iff (!RST_N)
		(is_cond_rd && CMD_SINGLE) |=> RSP_VALID && RSP_DATA[15:1] == 15'h0)
		else $error("bit read not 0/1");

	COV_SCAN_MEAS: cover property (@(posedge MCLK) disable iff (!RST_N) MEAS_START && SCAN_END);
	COV_ZERO_ASC: cover property (@(posedge MCLK) disable iff (!RST_N) TP_ASC_VALID);
	COV_SVC: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(SERVICE_LED));
	COV_ASSERT: cover property (@(posedge MCLK) disable iff (!RST_N) is_assert && |COND);
endmodule

// File: sepg_pkg.sv
package sepg_pkg;
	localparam int             NGRP        = 10;
	localparam int             NBIT        = 16;
	localparam logic [3:0]     LAST_GRP    = 4'h9;
	localparam logic [15:0]    EN_RST      = 16'hffff;
	localparam logic [9:0]     SVC_RST     = 10'h3ff;
	localparam logic           TP_EN_RST   = 1'b1;
	localparam logic [31:0]    FLOAT_ZERO  = 32'h0000_0000;
	localparam logic [7:0]     ASCII_0     = 8'h30;
	localparam logic [7:0]     ASCII_DOT   = 8'h2e;
	localparam int             CMD_W       = 4;
	localparam int             ASCII_ZLEN  = 3;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_COND_RD, CMD_EVT_RD, CMD_EN_RD, CMD_EN_WR, CMD_ASSERT,
		CMD_DEFMASK, CMD_GLOBAL_RD, CMD_SVC_RD, CMD_SVC_WR, CMD_TP_EN_WR, CMD_TP_EN_RD
	} sepg_cmd_t;
	typedef enum logic [1:0] {TP_IDLE, TP_MEAS, TP_SEND} sepg_tp_t;
endpackage

// File: sepg_grp_mem.sv
`timescale 1ns/10ps
// per-group event enable store; all groups drive en_all straight from their flops
module sepg_grp_mem
	import sepg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        defaults,
	input  wire logic        wr,
	input  wire logic [3:0]  wr_grp,
	input  wire logic [15:0] wr_data,
	input  wire logic [15:0] wr_mask,
	output logic [NGRP*NBIT-1:0] en_all
);
	logic [NBIT-1:0] en_ff [NGRP];
	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : gg
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					en_ff[g] <= EN_RST;
				else if (defaults)
					en_ff[g] <= EN_RST;
				else if (wr && wr_grp == 4'(g))
					en_ff[g] <= (en_ff[g] & ~wr_mask) | (wr_data & wr_mask);
			end
			assign en_all[g*NBIT +: NBIT] = en_ff[g];
		end
	endgenerate
endmodule

// File: sepg_meas_model.sv
`timescale 1ns/10ps
// electrometer stand-in: answers each start after a few cycles
module sepg_meas_model
	import sepg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic [31:0] value,
	output logic             done,
	output logic [31:0]      result
);
	int cnt = 0;
	// result is only meaningful with done; scrambled otherwise
	always @(posedge clk) begin
		if (start === 1'b1)
			cnt <= 6;
		else if (cnt > 0)
			cnt <= cnt - 1;
		done <= (cnt == 1);
		result <= (cnt == 1) ? value : ~result;
	end
endmodule

// File: test_status_event_and_pressure_gate.sv
`timescale 1ns/10ps
module test_status_event_and_pressure_gate;
	import sepg_pkg::*;
	logic         mclk, rst_n, cmd_valid, cmd_single, rsp_valid, mvnz, scan_end, tp_query;
	logic         meas_start, meas_done, bin_v, asc_v, raw_v, tp_en, led;
	logic [159:0] cond;
	logic [3:0]   cmd_code, cmd_grp, cmd_bit;
	logic [15:0]  cmd_data, rsp_data, rsp;
	logic [31:0]  meas_float, mval, tp_raw, w;
	logic [7:0]   bin_b, asc_b;
	logic [9:0]   gsum;
	int           errors = 0, checks_done = 0, starts = 0, cyc = 0, s0;
	sepg_top i_sepg_top (.MCLK(mclk), .RST_N(rst_n), .COND(cond), .CMD_VALID(cmd_valid),
		.CMD_CODE(cmd_code), .CMD_GRP(cmd_grp), .CMD_SINGLE(cmd_single), .CMD_BIT(cmd_bit),
		.CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .MULT_VOLT_NZ(mvnz),
		.SCAN_END(scan_end), .TP_QUERY(tp_query), .MEAS_START(meas_start),
		.MEAS_DONE(meas_done), .MEAS_FLOAT(meas_float), .TP_BIN_VALID(bin_v),
		.TP_BIN_BYTE(bin_b), .TP_ASC_VALID(asc_v), .TP_ASC_BYTE(asc_b), .TP_RAW_VALID(raw_v),
		.TP_RAW(tp_raw), .TP_ENABLED(tp_en), .SERVICE_LED(led), .GLOBAL_SUM(gsum));
	sepg_meas_model i_sepg_meas_model (.clk(mclk), .start(meas_start), .value(mval),
		.done(meas_done), .result(meas_float));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (meas_start === 1'b1)
			starts++;
		if (cyc == 20000) begin
			errors++;
			close_out;
		end
	end
	task close_out;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmd(input logic [3:0] c, g, input logic s, input logic [3:0] b, input logic [15:0] d);
		@(negedge mclk);
		{cmd_valid, cmd_code, cmd_grp, cmd_single, cmd_bit, cmd_data} = {1'b1, c, g, s, b, d};
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (int n = 0; n < 3 && rsp_valid !== 1'b1; n++)
			@(negedge mclk);
		rsp = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
	endtask
	task rd(input logic [3:0] c, g, input logic s, input logic [3:0] b, input logic [15:0] e);
		cmd(c, g, s, b, 16'h0);
		chk(rsp, e);
	endtask
	task cnd(input int g, input logic [15:0] v);
		@(negedge mclk);
		cond[16*g +: 16] = v;
		repeat (2) @(negedge mclk);
	endtask
	// gathers a byte stream, first byte lowest
	task grab(input int nb, input bit asc);
		w = 32'h0;
		for (int n = 0; n < 40 && (asc ? asc_v : bin_v) !== 1'b1; n++)
			@(negedge mclk);
		for (int i = 0; i < nb; i++) begin
			w = {(asc ? asc_b : bin_b), w[31:8]};
			if ((asc ? asc_v : bin_v) !== 1'b1)
				w = 32'hxxxx_xxxx;
			@(negedge mclk);
		end
	endtask
	task pulse(input bit q);
		@(negedge mclk);
		if (q) tp_query = 1'b1; else scan_end = 1'b1;
		@(negedge mclk);
		{tp_query, scan_end} = 2'b00;
	endtask
	task t_reset;
		chk(tp_en, 1'b1);
		chk({led, gsum}, 11'h0);
		rd(CMD_EN_RD, 4'h4, 1'b0, 4'h0, EN_RST);
	endtask
	task t_cond;
		cnd(2, 16'h0021);
		cnd(9, 16'h8000);
		rd(CMD_COND_RD, 4'h2, 1'b0, 4'h0, 16'h0021);
		rd(CMD_COND_RD, 4'h2, 1'b1, 4'h5, 16'h0001);
		rd(CMD_COND_RD, 4'h2, 1'b1, 4'h3, 16'h0000);
		rd(CMD_COND_RD, 4'h2, 1'b0, 4'h0, 16'h0021);
		rd(CMD_COND_RD, 4'ha, 1'b0, 4'h0, 16'h0000);
		chk({led, gsum}, {1'b1, 10'h204});
		rd(CMD_GLOBAL_RD, 4'h0, 1'b0, 4'h0, 16'h0204);
		rd(CMD_GLOBAL_RD, 4'h9, 1'b1, 4'h0, 16'h0001);
	endtask
	task t_event;
		rd(CMD_EVT_RD, 4'h2, 1'b1, 4'h5, 16'h0001);
		rd(CMD_EVT_RD, 4'h2, 1'b0, 4'h0, 16'h0001);
		rd(CMD_EVT_RD, 4'h2, 1'b0, 4'h0, 16'h0000);
		cmd(CMD_ASSERT, 4'h0, 1'b0, 4'h0, 16'h0);
		rd(CMD_EVT_RD, 4'h0, 1'b0, 4'h0, 16'h0000);
		rd(CMD_EVT_RD, 4'h2, 1'b0, 4'h0, 16'h0021);
		rd(CMD_EVT_RD, 4'h9, 1'b0, 4'h0, 16'h8000);
		chk(gsum, 10'h0);
		cmd(CMD_SVC_WR, 4'h0, 1'b0, 4'h0, 16'h0001);
		cmd(CMD_SVC_WR, 4'h9, 1'b1, 4'h0, 16'h0001);
		rd(CMD_SVC_RD, 4'h0, 1'b0, 4'h0, 16'h0201);
		rd(CMD_SVC_RD, 4'h9, 1'b1, 4'h0, 16'h0001);
		cnd(2, 16'h0);
		cnd(2, 16'h0021);
		chk({led, gsum}, {1'b0, 10'h004});
	endtask
	task t_enable;
		cmd(CMD_EN_WR, 4'h2, 1'b0, 4'h0, 16'h0001);
		cmd(CMD_EN_WR, 4'h2, 1'b1, 4'h5, 16'h0001);
		cmd(CMD_EN_WR, 4'h2, 1'b1, 4'h0, 16'h0000);
		rd(CMD_EN_RD, 4'h2, 1'b0, 4'h0, 16'h0020);
		rd(CMD_EVT_RD, 4'h2, 1'b0, 4'h0, 16'h0021);
		cnd(2, 16'h0);
		cnd(2, 16'h0021);
		rd(CMD_EVT_RD, 4'h2, 1'b0, 4'h0, 16'h0020);
		cmd(CMD_DEFMASK, 4'h0, 1'b0, 4'h0, 16'h0);
		rd(CMD_EN_RD, 4'h2, 1'b0, 4'h0, EN_RST);
		rd(CMD_SVC_RD, 4'h0, 1'b0, 4'h0, {6'h0, SVC_RST});
	endtask
	task t_tp;
		s0 = starts;
		pulse(0);
		grab(4, 0);
		chk(w, mval);
		pulse(1);
		for (int n = 0; n < 40 && raw_v !== 1'b1; n++)
			@(negedge mclk);
		chk(raw_v, 1'b1);
		chk(tp_raw, mval);
		chk(starts, s0 + 2);
		mvnz = 1'b1;
		repeat (4) @(negedge mclk);
		chk(tp_en, 1'b0);
		rd(CMD_TP_EN_RD, 4'h0, 1'b0, 4'h0, 16'h0000);
		pulse(1);
		grab(3, 1);
		chk(w, {ASCII_0, ASCII_DOT, ASCII_0, 8'h00});
		pulse(0);
		grab(4, 0);
		chk(w, FLOAT_ZERO);
		chk(starts, s0 + 2);
		cmd(CMD_TP_EN_WR, 4'h0, 1'b0, 4'h0, 16'h0001);
		rd(CMD_TP_EN_RD, 4'h0, 1'b0, 4'h0, 16'h0001);
		chk(tp_en, 1'b1);
		mvnz = 1'b0;
	endtask
	initial begin
		{rst_n, cmd_valid, cmd_single, mvnz, scan_end, tp_query} = 6'h0;
		{cmd_code, cmd_grp, cmd_bit, cmd_data} = 28'h0;
		cond = 160'h0;
		mval = 32'h4048_0f10;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		t_reset;
		t_cond;
		t_event;
		t_enable;
		t_tp;
		close_out;
	end
endmodule
